// [hw/sfc_regs.svh]
`ifndef SFC_REGS_SVH
`define SFC_REGS_SVH
// opcodes
`define SFC_OP_WREN 8'h06
`define SFC_OP_CE_A 8'h60
`define SFC_OP_CE_B 8'hC7
`define SFC_OP_QPI_EN 8'h38
`define SFC_OP_QPI_DIS 8'hFF
`define SFC_OP_DPD 8'hB9
`define SFC_OP_REL 8'hAB
`define SFC_OP_RSTEN 8'h66
`define SFC_OP_RST 8'h99
`define SFC_OP_UID 8'h4B
`define SFC_OP_ID_A 8'h9F
`define SFC_OP_ID_B 8'h9E
`define SFC_OP_SUS 8'h75
`define SFC_OP_RES 8'h7A
`define SFC_OP_SRER 8'h44
`define SFC_OP_SRPG 8'h42
`define SFC_OP_WRSR 8'h01
`define SFC_OP_WRCR 8'hB1
// reset values
`define SFC_BP_RST 3'h0
// timing, ns and derived cycles at 100 MHz
`define SFC_CLK_NS 10
`define SFC_RES_NS 200
`define SFC_RES_CYC ((`SFC_RES_NS + `SFC_CLK_NS - 1) / `SFC_CLK_NS)
`define SFC_DP_NS 3000
`define SFC_DP_CYC ((`SFC_DP_NS + `SFC_CLK_NS - 1) / `SFC_CLK_NS)
`define SFC_REL_NS 30000
`define SFC_REL_CYC ((`SFC_REL_NS + `SFC_CLK_NS - 1) / `SFC_CLK_NS)
`define SFC_SUS_NS 1000
`define SFC_SUS_CYC (`SFC_SUS_NS / `SFC_CLK_NS)
`define SFC_CE_CYC 20000
`define SFC_SE_CYC 8000
`endif

// [hw/sfc_pkg.sv]
package sfc_pkg;
   typedef enum logic [4:0]
   {
      SFC_IDLE = 5'b0_0001,
      SFC_BUSY = 5'b0_0010,
      SFC_SUSP = 5'b0_0100,
      SFC_DPD = 5'b0_1000,
      SFC_REL = 5'b1_0000
   } sfc_state_type;
   typedef enum logic [1:0]
   {
      SFC_OP_NONE = 2'b00,
      SFC_OP_PROG = 2'b01,
      SFC_OP_ERASE = 2'b10
   } sfc_kind_type;
endpackage

// [hw/sfc_sync.sv]
`timescale 1ns/1ps
module sfc_sync #(parameter int W = 1)
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_r;
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         meta_r <= '0;
         q <= '0;
      end
      else
      begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule

// [hw/sfc_timer.sv]
`timescale 1ns/1ps
module sfc_timer #(parameter int W = 20)
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic load,
   input wire logic [W-1:0] count,
   input wire logic hold,
   output logic done
);
   // hold freezes the count, used while a cycle is suspended
   logic [W-1:0] cnt_r;
   logic run_r;
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         cnt_r <= '0;
         run_r <= 1'b0;
         done <= 1'b0;
      end
      else
      begin
         done <= 1'b0;
         if (load)
         begin
            cnt_r <= count;
            run_r <= 1'b1;
         end
         else if (run_r && !hold)
         begin
            if (cnt_r <= 1)
            begin
               run_r <= 1'b0;
               done <= 1'b1;
            end
            else
               cnt_r <= cnt_r - 1'b1;
         end
      end
   end
endmodule

// [hw/sfc_cmd.sv]
`timescale 1ns/1ps
`include "sfc_regs.svh"
// Summary of operation
// - chip erase runs only if select rises right after eight opcode bits
// - chip erase sets busy until done and clears write enable latch
// - chip erase ignored unless all block protect bits are zero
// - opcode 38h switches into four-line instruction mode
// - mode switches keep write enable latch, suspend state and wrap
// - opcode FFh in four-line mode returns to serial mode
// - deep power-down needs exact eight bits, enters after entry delay
// - in deep power-down only release and reset pair are obeyed
// - deep power-down rejected while a cycle is busy
// - deselect without a cycle is standby; reset starts in standby
// - after release nothing is accepted until release delay passes
// - release ignored while busy, cycle untouched
// - unique id read: opcode, zero address, dummy, then 128 bits out
// - id read sends maker, type, capacity bytes on falling edges
// - id read not decoded while erase or program runs
// - suspend accepted only if not suspended and program/erase busy
// - accepted suspend sets suspend at once, clears busy in latency
// - program suspend refuses register writes, erases, programs
// - erase suspend refuses register writes and erases; ext_prog_start also needs SFC_IDLE
// - resume only if suspended and idle; busy returns one cycle after the 200 ns delay
// - security erase needs write enable, address, self-timed busy
// - security erase ignored once lock bit set; address low byte zero
// - chip erase needs write enable latch set beforehand
module sfc_cmd #(
   parameter int CE_CYC = `SFC_CE_CYC,
   parameter int SE_CYC = `SFC_SE_CYC,
   parameter int DP_CYC = `SFC_DP_CYC,
   parameter int REL_CYC = `SFC_REL_CYC,
   parameter logic [7:0] MAKER_ID = 8'hA5, // arbitrary value
   parameter logic [7:0] TYPE_ID = 8'h5A, // arbitrary value
   parameter logic [7:0] CAP_ID = 8'h3C, // arbitrary value
   parameter logic [127:0] UNIQUE_ID =
      128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210,
   parameter int ADDR_BYTES = 3
)
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic [3:0] io_in,
   output logic [3:0] io_out,
   output logic [3:0] io_oe,
   input wire logic [2:0] block_protect_bits,
   input wire logic sec_lock,
   input wire logic ext_prog_start,
   output logic busy_flag,
   output logic write_enable_latch,
   output logic [1:0] suspend_flags,
   output logic four_line_instruction_mode,
   output logic deep_power_down,
   output logic [1:0] wrap_len
);
   import sfc_pkg::*;
   localparam int TW = 20;
   logic cs_s, sck_s, cs_d_r, sck_d_r;
   logic [3:0] io_s;
   logic rise, fall, sel_end;
   logic sel_s;
   // select synced inverted: reset reads as deselected, no false frame end
   sfc_sync #(.W(6)) u_sync
   (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .d({!cs_n, sclk, io_in}),
      .q({sel_s, sck_s, io_s})
   );
   assign cs_s = !sel_s;
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         cs_d_r <= 1'b1;
         sck_d_r <= 1'b0;
      end
      else
      begin
         cs_d_r <= cs_s;
         sck_d_r <= sck_s;
      end
   end
   assign rise = !cs_s && sck_s && !sck_d_r;
   assign fall = !cs_s && !sck_s && sck_d_r;
   assign sel_end = cs_s && !cs_d_r;

   // ----------------------------------------
   // shift in
   // ----------------------------------------
   logic [7:0] op_r;
   logic [7:0] sh_r;
   logic [9:0] bits_r;
   logic op_ok_r, rst_en_r;
   logic [7:0] sh_nxt;
   always_comb
   begin
      if (four_line_instruction_mode)
         sh_nxt = {sh_r[3:0], io_s};
      else
         sh_nxt = {sh_r[6:0], io_s[0]};
   end
   logic [9:0] step;
   assign step = four_line_instruction_mode ? 10'd4 : 10'd1;
   always_ff @(posedge mclk)
   begin
      if (sys_rst || sel_end)
      begin
         bits_r <= '0;
         sh_r <= '0;
         op_r <= '0;
         op_ok_r <= 1'b0;
      end
      else if (rise)
      begin
         sh_r <= sh_nxt;
         if (bits_r != 10'h3FF)
            bits_r <= bits_r + step;
         if (bits_r + step == 10'd8)
         begin
            op_r <= sh_nxt;
            op_ok_r <= 1'b1;
         end
      end
   end
   // exact opcode length for one-byte commands, address length for 44h
   logic exact8, exact_addr;
   assign exact8 = op_ok_r && bits_r == 10'd8;
   assign exact_addr = op_ok_r &&
      bits_r == 10'(8 + 8 * ADDR_BYTES);

   // ----------------------------------------
   // state machine
   // ----------------------------------------
   sfc_state_type st_r;
   sfc_kind_type kind_r;
   logic tload, tdone, thold;
   logic [TW-1:0] tcount;
   logic susp_wait_r, dpd_pend_r;
   logic [TW-1:0] wait_r;
   logic busy_nxt;
   sfc_timer #(.W(TW)) u_timer
   (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .load(tload),
      .count(tcount),
      .hold(thold),
      .done(tdone)
   );
   logic is_ce, is_srer, blocked, ready;
   assign ready = st_r == SFC_IDLE && wait_r == '0;
   assign is_ce = op_r == `SFC_OP_CE_A || op_r == `SFC_OP_CE_B;
   assign is_srer = op_r == `SFC_OP_SRER;
   // refused opcodes during suspend
   always_comb
   begin
      blocked = 1'b0;
      if (st_r == SFC_SUSP)
      begin
         if (op_r == `SFC_OP_WRSR || op_r == `SFC_OP_WRCR || is_ce ||
             is_srer || op_r == 8'h20 || op_r == 8'h21 || op_r == 8'h52 ||
             op_r == 8'h5C || op_r == 8'hD8 || op_r == 8'hDC)
            blocked = 1'b1;
         if (kind_r == SFC_OP_PROG && (op_r == `SFC_OP_SRPG ||
             op_r == 8'h02 || op_r == 8'h12 || op_r == 8'h32 ||
             op_r == 8'h34 || op_r == 8'hC2 || op_r == 8'h3E))
            blocked = 1'b1;
      end
   end
   always_comb
   begin
      tload = 1'b0;
      tcount = '0;
      if (sel_end && exact8 && is_ce && ready && write_enable_latch &&
          block_protect_bits == `SFC_BP_RST)
      begin
         tload = 1'b1;
         tcount = TW'(CE_CYC);
      end
      else if (sel_end && exact_addr && is_srer && ready &&
               write_enable_latch && !sec_lock &&
               sh_r == '0 && suspend_flags == 2'b00)
      begin
         tload = 1'b1;
         tcount = TW'(SE_CYC);
      end
      else if (ext_prog_start && st_r == SFC_IDLE)
      begin
         tload = 1'b1;
         tcount = TW'(SE_CYC);
      end
   end
   assign thold = st_r != SFC_BUSY;
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         st_r <= SFC_IDLE;
         kind_r <= SFC_OP_NONE;
         busy_flag <= 1'b0;
         suspend_flags <= 2'b00;
         deep_power_down <= 1'b0;
         wait_r <= '0;
         dpd_pend_r <= 1'b0;
         susp_wait_r <= 1'b0;
         rst_en_r <= 1'b0;
      end
      else
      begin
         if (wait_r != '0)
            wait_r <= wait_r - 1'b1;
         if (sel_end && exact8)
            rst_en_r <= op_r == `SFC_OP_RSTEN;
         case (st_r)
            SFC_IDLE:
            begin
               if (tload)
               begin
                  st_r <= SFC_BUSY;
                  busy_flag <= 1'b1;
                  kind_r <= ext_prog_start && !sel_end ?
                     SFC_OP_PROG : SFC_OP_ERASE;
               end
               else if (dpd_pend_r && wait_r == '0)
               begin
                  dpd_pend_r <= 1'b0;
                  st_r <= SFC_DPD;
                  deep_power_down <= 1'b1;
               end
               else if (sel_end && exact8 && ready &&
                        op_r == `SFC_OP_DPD)
               begin
                  dpd_pend_r <= 1'b1;
                  wait_r <= TW'(DP_CYC);
               end
               else if (sel_end && exact8 && ready &&
                        op_r == `SFC_OP_RES && suspend_flags != 2'b00 &&
                        !busy_flag)
               begin
                  suspend_flags <= 2'b00;
                  wait_r <= TW'(`SFC_RES_CYC);
                  susp_wait_r <= 1'b1;
               end
               else if (susp_wait_r && wait_r == '0)
               begin
                  susp_wait_r <= 1'b0;
                  busy_flag <= 1'b1;
                  st_r <= SFC_BUSY;
               end
            end
            SFC_BUSY:
            begin
               if (tdone)
               begin
                  st_r <= SFC_IDLE;
                  busy_flag <= 1'b0;
                  kind_r <= SFC_OP_NONE;
               end
               else if (sel_end && exact8 && op_r == `SFC_OP_SUS &&
                        suspend_flags == 2'b00)
               begin
                  st_r <= SFC_SUSP;
                  suspend_flags <= kind_r == SFC_OP_PROG ?
                     2'b01 : 2'b10;
                  wait_r <= TW'(`SFC_SUS_CYC);
               end
            end
            SFC_SUSP:
            begin
               if (busy_flag && wait_r == '0)
                  busy_flag <= 1'b0;
               if (sel_end && exact8 && op_r == `SFC_OP_RES &&
                   !busy_flag)
               begin
                  suspend_flags <= 2'b00;
                  wait_r <= TW'(`SFC_RES_CYC);
                  susp_wait_r <= 1'b1;
                  st_r <= SFC_IDLE;
               end
            end
            SFC_DPD:
            begin
               if (sel_end && exact8 && (op_r == `SFC_OP_REL ||
                   (op_r == `SFC_OP_RST && rst_en_r)))
               begin
                  deep_power_down <= 1'b0;
                  st_r <= SFC_REL;
                  wait_r <= TW'(REL_CYC);
               end
            end
            SFC_REL:
            begin
               if (wait_r == '0)
                  st_r <= SFC_IDLE;
            end
            default:
               st_r <= SFC_IDLE;
         endcase
      end
   end
   // suspended cycle stays in SFC_IDLE while resume delay runs
   // then re-enters busy with the timer still frozen, hence hold

   // ----------------------------------------
   // mode and latch
   // ----------------------------------------
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         four_line_instruction_mode <= 1'b0;
         write_enable_latch <= 1'b0;
         wrap_len <= 2'b00;
      end
      else
      begin
         if (sel_end && exact8 && ready && op_r == `SFC_OP_QPI_EN)
            four_line_instruction_mode <= 1'b1;
         else if (sel_end && exact8 && ready &&
                  four_line_instruction_mode && op_r == `SFC_OP_QPI_DIS)
            four_line_instruction_mode <= 1'b0;
         if (tdone)
            write_enable_latch <= 1'b0;
         else if (sel_end && exact8 && op_r == `SFC_OP_WREN &&
                  (st_r == SFC_IDLE || st_r == SFC_SUSP) && !blocked)
            write_enable_latch <= 1'b1;
      end
   end

   // ----------------------------------------
   // shift out
   // ----------------------------------------
   logic [127:0] out_r;
   logic out_on_r;
   logic [127:0] out_src;
   logic out_ld;
   // load and first bit share one fall, so serial id data starts on the ninth fall, unique id data on the 41st
   always_comb
   begin
      out_ld = 1'b0;
      out_src = out_r;
      if (!out_on_r && exact8 && ready &&
          (op_r == `SFC_OP_ID_A || op_r == `SFC_OP_ID_B))
      begin
         out_ld = 1'b1;
         out_src = {MAKER_ID, TYPE_ID, CAP_ID, 104'h0};
      end
      else if (!out_on_r && op_ok_r && op_r == `SFC_OP_UID && ready &&
               bits_r == 10'(16 + 8 * ADDR_BYTES))
      begin
         out_ld = 1'b1;
         out_src = UNIQUE_ID;
      end
   end
   always_ff @(posedge mclk)
   begin
      if (sys_rst || sel_end)
      begin
         out_r <= '0;
         out_on_r <= 1'b0;
         io_out <= 4'h0;
         io_oe <= 4'h0;
      end
      else if (fall && (out_on_r || out_ld))
      begin
         out_on_r <= 1'b1;
         if (four_line_instruction_mode)
         begin
            io_out <= out_src[127:124];
            io_oe <= 4'hF;
            out_r <= {out_src[123:0], 4'h0};
         end
         else
         begin
            io_out <= {2'b00, out_src[127], 1'b0};
            io_oe <= 4'h2;
            out_r <= {out_src[126:0], 1'b0};
         end
      end
   end
endmodule

// [bench/sfc_cmd_sva.sv]
`timescale 1ns/1ps
module sfc_cmd_sva #(parameter int DP_CYC = 300)
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic cs_n,
   input wire logic [3:0] io_oe,
   input wire logic busy_flag,
   input wire logic write_enable_latch,
   input wire logic [1:0] suspend_flags,
   input wire logic four_line_instruction_mode,
   input wire logic deep_power_down,
   input wire logic [1:0] wrap_len
);
   localparam int SUS_MAX = 110;
   localparam int RES_MAX = 25;
   logic [15:0] hi_r;
   // ----
   // deselect time, saturating
   // ----
   always_ff @(posedge mclk)
   begin
      if (sys_rst || !cs_n)
         hi_r <= 16'h0000;
      else if (hi_r != 16'hFFFF)
         hi_r <= hi_r + 16'h0001;
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);
   sequence s_sus_set;
      $rose(|suspend_flags);
   endsequence
   sequence s_resumed;
      $fell(|suspend_flags) ##0 !busy_flag;
   endsequence
   property p_wel_clear;
      $fell(busy_flag) && suspend_flags == 2'b00 |-> !write_enable_latch;
   endproperty
   a_wel_clear: assert property (p_wel_clear) else $error("wel kept");
   property p_dpd_entry;
      $rose(deep_power_down) |-> hi_r >= DP_CYC;
   endproperty
   a_dpd_entry: assert property (p_dpd_entry) else $error("dpd early");
   property p_dpd_idle;
      deep_power_down |-> !busy_flag;
   endproperty
   a_dpd_idle: assert property (p_dpd_idle) else $error("dpd busy");
   property p_dpd_hold;
      deep_power_down && $past(deep_power_down)
         |-> $stable(four_line_instruction_mode);
   endproperty
   a_dpd_hold: assert property (p_dpd_hold) else $error("dpd obeyed");
   property p_sus_ok;
      s_sus_set |-> $past(busy_flag) && $past(suspend_flags) == 2'b00;
   endproperty
   a_sus_ok: assert property (p_sus_ok) else $error("bad suspend");
   property p_sus_idle;
      s_sus_set |-> ##[0:SUS_MAX] !busy_flag;
   endproperty
   a_sus_idle: assert property (p_sus_idle) else $error("sus slow");
   property p_resume;
      s_resumed |-> ##[1:RES_MAX] busy_flag;
   endproperty
   a_resume: assert property (p_resume) else $error("resume slow");
   property p_mode_keep;
      $changed(four_line_instruction_mode) |-> $stable(write_enable_latch)
         && $stable(suspend_flags) && $stable(wrap_len);
   endproperty
   a_mode_keep: assert property (p_mode_keep) else $error("mode lost");
   property p_oe_mode;
      io_oe != 4'h0
         |-> io_oe == (four_line_instruction_mode ? 4'hF : 4'h2);
   endproperty
   a_oe_mode: assert property (p_oe_mode) else $error("oe width");
   property p_oe_idle;
      hi_r > 16'h0006 |-> io_oe == 4'h0;
   endproperty
   a_oe_idle: assert property (p_oe_idle) else $error("oe idle");
endmodule
bind sfc_cmd sfc_cmd_sva #(.DP_CYC(DP_CYC)) chk_u
(
   .mclk(mclk), .sys_rst(sys_rst), .cs_n(cs_n), .io_oe(io_oe),
   .busy_flag(busy_flag), .write_enable_latch(write_enable_latch),
   .suspend_flags(suspend_flags), .wrap_len(wrap_len),
   .four_line_instruction_mode(four_line_instruction_mode),
   .deep_power_down(deep_power_down)
);

// [bench/sfc_host.sv]
`timescale 1ns/1ps
module sfc_host
(
   input wire logic mclk,
   output logic cs_n,
   output logic sclk,
   output logic [3:0] io_in,
   input wire logic [3:0] io_out,
   input wire logic [3:0] io_oe
);
   // ----
   // host frames
   // ----
   // clock idles high, so read data follows the first fall after the last sent bit (the ninth for an opcode alone)
   initial
   begin
      cs_n = 1'b1;
      sclk = 1'b1;
      io_in = 4'h0;
   end
   task automatic xfer(input logic [63:0] d, input int n, input bit q,
      input int nrd, output logic [31:0] rd);
      int i;
      rd = 32'h0000_0000;
      @(posedge mclk);
      #1 cs_n = 1'b0;
      #100;
      for (i = 0; i < n; i = i + (q ? 4 : 1))
      begin
         sclk = 1'b0;
         if (q)
            io_in = d[63-i -: 4];
         else
            io_in[0] = d[63-i];
         #62.5 sclk = 1'b1;
         #62.5;
      end
      for (i = 0; i < nrd; i++)
      begin
         sclk = 1'b0;
         #62.5 sclk = 1'b1;
         rd = {rd[30:0], io_out[1]};
         #62.5;
      end
      // select rises right after the last bit
      cs_n = 1'b1;
      io_in = ~io_in;
   endtask
endmodule

// [bench/testbench.sv]
`timescale 1ns/1ps
module testbench;
   localparam int CE = 600;
   localparam int SE = 700;
   localparam int DP = 40;
   localparam int REL = 400;
   localparam logic [23:0] IDS = 24'hC3_1E77; // arbitrary value
   localparam logic [127:0] UID =
      128'h9A3C_5E71_0B2D_4F68_1357_2468_ACE0_BDF1;
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic cs_n, sclk;
   logic [3:0] io_in, io_out, io_oe;
   logic [2:0] block_protect_bits = 3'h0;
   logic sec_lock = 1'b0;
   logic ext_prog_start = 1'b0;
   logic busy_flag, write_enable_latch, four_line_instruction_mode;
   logic deep_power_down;
   logic [1:0] suspend_flags, wrap_len;
   logic [31:0] rd;
   logic [7:0] ce_ops [2] = '{8'h60, 8'hC7};
   int num_errors = 0;
   int compares = 0;
   int seed;
   always #5 mclk = ~mclk;
   sfc_host host_u (.mclk(mclk), .cs_n(cs_n), .sclk(sclk), .io_in(io_in),
      .io_out(io_out), .io_oe(io_oe));
   sfc_cmd #(.CE_CYC(CE), .SE_CYC(SE), .DP_CYC(DP), .REL_CYC(REL),
      .MAKER_ID(IDS[23:16]), .TYPE_ID(IDS[15:8]), .CAP_ID(IDS[7:0]),
      .UNIQUE_ID(UID)) dut_u (.mclk(mclk), .sys_rst(sys_rst), .cs_n(cs_n),
      .sclk(sclk), .io_in(io_in), .io_out(io_out), .io_oe(io_oe),
      .block_protect_bits(block_protect_bits), .sec_lock(sec_lock),
      .ext_prog_start(ext_prog_start), .busy_flag(busy_flag),
      .write_enable_latch(write_enable_latch), .wrap_len(wrap_len),
      .suspend_flags(suspend_flags), .deep_power_down(deep_power_down),
      .four_line_instruction_mode(four_line_instruction_mode));
   // ----
   // helpers
   // ----
   task automatic check(input logic [31:0] seen, exp, input string m);
      compares++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED %0t %s", $time, m);
      end
   endtask
   task automatic pause(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   // the gap after each frame covers the select synchroniser
   task automatic xf(input logic [63:0] d, input int n, nrd = 0,
      input bit q = 0);
      host_u.xfer(d, n, q, nrd, rd);
      pause(10);
   endtask
   task automatic op(input logic [7:0] c, input bit q = 0);
      xf({c, 56'h0}, 8, 0, q);
   endtask
   task automatic wait_busy(input logic v);
      int n;
      n = 0;
      while (busy_flag !== v && n < 2000)
      begin
         @(posedge mclk);
         n++;
      end
      #1 check(busy_flag, v, "busy wait");
   endtask
   task automatic final_report;
      if (num_errors == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial
   begin
      #500000;
      num_errors++;
      final_report();
   end
   // ----
   // scenarios
   // ----
   initial
   begin
      seed = $urandom(18);
      pause(20);
      sys_rst = 1'b0;
      pause(3);
      check({busy_flag, write_enable_latch, suspend_flags, deep_power_down,
         four_line_instruction_mode, wrap_len}, 0, "reset");
      op(8'hC7);
      check(busy_flag, 0, "ce no wel");
      op(8'h06);
      check(write_enable_latch, 1, "wel");
      block_protect_bits = 3'($urandom_range(7, 1));
      op(8'hC7);
      check(busy_flag, 0, "ce protected");
      block_protect_bits = 3'h0;
      xf({8'hC7, 56'h0}, 9);
      check(busy_flag, 0, "ce bit count");
      foreach (ce_ops[i])
      begin
         op(8'h06);
         op(ce_ops[i]);
         check(busy_flag, 1, "ce start");
         op(8'hB9);
         op(8'hAB);
         op(8'h9F);
         check(busy_flag, 1, "busy cmds");
         check(deep_power_down, 0, "busy dpd");
         wait_busy(0);
         check(write_enable_latch, 0, "ce wel");
      end
      op(8'h06);
      op(8'h38);
      check(four_line_instruction_mode, 1, "on");
      check(write_enable_latch, 1, "on wel");
      op(8'hFF, 1);
      check(four_line_instruction_mode, 0, "off");
      check(write_enable_latch, 1, "off wel");
      repeat (2)
      begin
         xf({($urandom_range(1) ? 8'h9F : 8'h9E), 56'h0}, 8, 24);
         check(rd[23:0], IDS, "id");
      end
      xf(64'h4B00_0000_0000_0000, 40, 32);
      check(rd, UID[127:96], "uid");
      op(8'hB9);
      pause(DP + 20);
      check(deep_power_down, 1, "dpd on");
      op(8'h38);
      check(four_line_instruction_mode, 0, "dpd ignores");
      op(8'hAB);
      op(8'h38);
      check(four_line_instruction_mode, 0, "early cmd");
      pause(REL + 20);
      check(deep_power_down, 0, "released");
      op(8'hB9);
      pause(DP + 20);
      op(8'h66);
      op(8'h99);
      pause(REL + 20);
      check(deep_power_down, 0, "reset exit");
      op(8'h75);
      op(8'h7A);
      check({busy_flag, suspend_flags}, 0, "idle sus");
      ext_prog_start = 1'b1;
      pause(1);
      ext_prog_start = 1'b0;
      pause(5);
      op(8'h75);
      check(suspend_flags, 2'b01, "prog sus");
      wait_busy(0);
      op(8'h06);
      op(8'hC7);
      xf(64'h4400_0000_0000_0000, 32);
      op(8'h75);
      check({busy_flag, suspend_flags}, 3'b001, "refuse");
      op(8'h7A);
      check(suspend_flags, 0, "resume");
      wait_busy(1);
      wait_busy(0);
      sec_lock = 1'b1;
      op(8'h06);
      xf(64'h4400_0000_0000_0000, 32);
      check(busy_flag, 0, "locked");
      sec_lock = 1'b0;
      xf(64'h4400_0000_0000_0000, 32);
      check(busy_flag, 1, "sec erase");
      wait_busy(0);
      check(write_enable_latch, 0, "sec wel");
      final_report();
   end
endmodule
